// file: design/ubc_pkg.sv
// Package: register map, field layout, timing and types of the burst controller
package ubc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned AXI_AW        = 4;
  localparam int unsigned PULSE_W       = 8;
  localparam int unsigned SYNC_N        = 4;

  localparam logic [AXI_AW-1:0] OFS_CTRL   = 4'h0;
  localparam logic [AXI_AW-1:0] OFS_BURST  = 4'h4;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 4'h8;

  // Control word layout
  localparam int unsigned B_MODE_LO    = 0;
  localparam int unsigned B_CMD_TRIG   = 2;
  localparam int unsigned B_HI_Z       = 3;
  localparam int unsigned B_LSTN_DIS   = 4;
  localparam int unsigned B_RECHARGE   = 5;
  localparam int unsigned B_VLEVEL_LO  = 8;
  // Burst word layout
  localparam int unsigned B_PULSE_LO   = 0;
  localparam int unsigned B_FTIME_LO   = 8;
  // Status word layout
  localparam int unsigned B_READY      = 0;
  localparam int unsigned B_PCNT_FLT   = 1;
  localparam int unsigned B_STUCK_FLT  = 2;
  localparam int unsigned B_ACTIVE     = 3;
  localparam int unsigned B_ARMED      = 4;
  localparam int unsigned B_BLANK      = 5;

  localparam logic [2:0]  FTIME_CLEAR  = 3'h7;
  localparam logic [2:0]  FTIME_RESET  = 3'h7;
  localparam logic [3:0]  VLEVEL_RESET = 4'h0;
  localparam logic [PULSE_W-1:0] PULSE_RESET = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] MODE_SPI    = 2'h0;
  localparam logic [1:0] MODE_ENPIN  = 2'h1;
  localparam logic [1:0] MODE_DIRECT = 2'h2;
  localparam logic [1:0] MODE_SINGLE = 2'h3;

  // Stuck-drive window: (field + 1) units
  localparam int unsigned FAULT_UNIT_NS  = 1000;
  localparam int unsigned FAULT_UNIT_CYC =
    (FAULT_UNIT_NS / CLK_PERIOD_NS) > 0 ? FAULT_UNIT_NS / CLK_PERIOD_NS : 1;
  // Half period of the internal overlap clock
  localparam int unsigned INT_HALF_NS  = 1000;
  localparam int unsigned INT_HALF_CYC =
    (INT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_ACTIVE, ST_BLANK} ubc_state_e;

  typedef struct packed {
    logic [3:0]         vlevel;
    logic               recharge;
    logic               lstn_dis;
    logic               hi_z;
    logic               cmd_trig;
    logic [1:0]         mode;
    logic [2:0]         ftime;
    logic [PULSE_W-1:0] pulses;
  } ubc_cfg_s;
endpackage

// file: design/ubc_burst_ctrl.sv
// Burst controller: pin-driven burst modes, drive-supply gating, diagnostics
// Function
// - Charging stops once the monitored drive supply reaches the selected level.
// - Reset leaves high-impedance set; regulation starts only once it clears.
// - With listen-regulation-disable set, charging stops after a burst ends.
// - Setting recharge trigger restores charging after automatic disable.
// - Supply-ready status bit shows the supply reached its level while high-impedance is clear.
// - Recharge trigger still set at burst end keeps charging enabled.
// - High-impedance set makes listen-disable and recharge trigger ignored.
// - Mode field picks one of four modes; outputs move at later fall.
// - Mode 0 arms on command trigger, starts at second pin fall.
// - Mode 0 ends at pulse count or command trigger clear.
// - Mode 0 needs trigger low then high again before rearming.
// - Mode 1 arms on first pin low, ends at count or rise.
// - Mode 1 needs first pin high then low again to rearm.
// - Mode 2 arms on any fall, starts on first pin fall, follows pins.
// - Mode 2 overlap over half internal period ends and disarms burst.
// - Mode 3 one fall of second pin arms and starts; ends at count.
// - Mode 3 blank-out of fault time after burst blocks new starts.
// - Count zero bursts continuously in modes 0 and 1, not mode 3.
// - Modes 0, 1, 3 flag short pulse count at burst end.
// - No toggle within fault time forces end and sets stuck flag.
// - Stuck flag clears on start, fault time write 7, or standby.
// - Pulse-count flag clears on start or standby entry.
`timescale 1ns/1ps
module ubc_burst_ctrl
  import ubc_pkg::*;
#(
  parameter int unsigned FAULT_UNIT = FAULT_UNIT_CYC,
  parameter int unsigned OVL_CYC    = INT_HALF_CYC
)(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              first_io_pin,
  input  wire logic              second_io_pin,
  input  wire logic              supply_at_level,
  input  wire logic              standby_mode,
  output logic                   drive_out_a,
  output logic                   drive_out_b,
  output logic                   charge_enable,
  output logic [3:0]             drive_voltage_level
);
  localparam int unsigned TMR_W = 16;

  initial
  begin
    if (FAULT_UNIT < 1 || 8 * FAULT_UNIT >= (1 << TMR_W))
      $error("FAULT_UNIT out of range");
    if (OVL_CYC < 1 || OVL_CYC >= (1 << TMR_W))
      $error("OVL_CYC out of range");
  end

  // Pin synchronisers: three stages, a change counts when 2 and 3 agree
  logic [SYNC_N-1:0] async_in;
  logic [SYNC_N-1:0] s1_q;
  logic [SYNC_N-1:0] s2_q;
  logic [SYNC_N-1:0] s3_q;
  logic [SYNC_N-1:0] lvl_q;
  assign async_in = {standby_mode, supply_at_level, second_io_pin,
                     first_io_pin};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          s1_q[gi]  <= 1'b1;
          s2_q[gi]  <= 1'b1;
          s3_q[gi]  <= 1'b1;
          lvl_q[gi] <= 1'b1;
        end
        else
        begin
          s1_q[gi] <= async_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            lvl_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  ubc_cfg_s cfg_q;
  logic io1_new;
  logic io2_new;
  logic io1_fall;
  logic io1_rise;
  logic io2_fall;
  logic io_toggle;
  logic standby_entry;
  assign io1_new  = (s2_q[0] == s3_q[0]) ? s3_q[0] : lvl_q[0];
  assign io2_new  = (s2_q[1] == s3_q[1]) ? s3_q[1] : lvl_q[1];
  assign io1_fall = lvl_q[0] & ~io1_new;
  assign io1_rise = ~lvl_q[0] & io1_new;
  assign io2_fall = lvl_q[1] & ~io2_new;
  assign io_toggle = (lvl_q[1] != io2_new) |
                     ((cfg_q.mode == MODE_DIRECT) & (lvl_q[0] != io1_new));
  assign standby_entry = (s2_q[3] == s3_q[3]) & s3_q[3] & ~lvl_q[3];

  // Register file
  logic     ftime_clr_wr;
  logic     recharge_set;
  logic     cmd_rise;
  logic     cmd_prev_q;

  // AXI4-Lite write: address and data taken in either order
  logic              aw_have_q;
  logic              w_have_q;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              wr_fire;
  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb_q      <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_have_q & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_have_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_have_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q == OFS_CTRL || aw_addr_q == OFS_BURST) ?
                        RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign ftime_clr_wr = wr_fire & (aw_addr_q == OFS_BURST) & w_strb_q[1] &
                        (w_data_q[B_FTIME_LO +: 3] == FTIME_CLEAR);
  assign recharge_set = wr_fire & (aw_addr_q == OFS_CTRL) & w_strb_q[0] &
                        w_data_q[B_RECHARGE] & ~cfg_q.recharge;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg_q.vlevel   <= VLEVEL_RESET;
      cfg_q.recharge <= 1'b0;
      cfg_q.lstn_dis <= 1'b0;
      cfg_q.hi_z     <= 1'b1;
      cfg_q.cmd_trig <= 1'b0;
      cfg_q.mode     <= MODE_SPI;
      cfg_q.ftime    <= FTIME_RESET;
      cfg_q.pulses   <= PULSE_RESET;
    end
    else if (wr_fire && aw_addr_q == OFS_CTRL)
    begin
      if (w_strb_q[0])
      begin
        cfg_q.mode     <= w_data_q[B_MODE_LO +: 2];
        cfg_q.cmd_trig <= w_data_q[B_CMD_TRIG];
        cfg_q.hi_z     <= w_data_q[B_HI_Z];
        cfg_q.lstn_dis <= w_data_q[B_LSTN_DIS];
        cfg_q.recharge <= w_data_q[B_RECHARGE];
      end
      if (w_strb_q[1])
        cfg_q.vlevel <= w_data_q[B_VLEVEL_LO +: 4];
    end
    else if (wr_fire && aw_addr_q == OFS_BURST)
    begin
      if (w_strb_q[0])
        cfg_q.pulses <= w_data_q[B_PULSE_LO +: PULSE_W];
      if (w_strb_q[1])
        cfg_q.ftime <= w_data_q[B_FTIME_LO +: 3];
    end
  end

  // Burst sequencer
  ubc_state_e         state_q;
  logic [PULSE_W-1:0] count_q;
  logic [TMR_W-1:0]   tmr_q;
  logic [TMR_W-1:0]   ovl_q;
  logic [TMR_W-1:0]   fault_win;
  logic               counted;
  logic               overlap;
  logic               stuck;
  logic               start;
  logic               stop;
  logic               short_count;
  logic               pcnt_flt_q;
  logic               stuck_flt_q;
  logic               lstn_off_q;

  assign fault_win = TMR_W'((32'(cfg_q.ftime) + 1) * FAULT_UNIT);
  assign cmd_rise  = cfg_q.cmd_trig & ~cmd_prev_q;
  // Count zero never completes, giving continuous bursts in modes 0 and 1
  assign counted   = (cfg_q.pulses != '0) && io2_fall &&
                     (count_q + PULSE_W'(1) == cfg_q.pulses);
  assign overlap   = (ovl_q >= TMR_W'(OVL_CYC));
  assign stuck     = (tmr_q >= fault_win);
  assign short_count = (cfg_q.mode != MODE_DIRECT) &&
                       (count_q != cfg_q.pulses);

  always_comb
  begin
    start = 1'b0;
    stop  = 1'b0;
    unique case (state_q)
      ST_ARMED:
        start = (cfg_q.mode == MODE_DIRECT) ? io1_fall : io2_fall;
      ST_IDLE:
        start = (cfg_q.mode == MODE_SINGLE) & io2_fall;
      ST_ACTIVE:
      begin
        unique case (cfg_q.mode)
          MODE_SPI:    stop = counted | ~cfg_q.cmd_trig;
          MODE_ENPIN:  stop = counted | io1_rise;
          MODE_DIRECT: stop = overlap;
          MODE_SINGLE: stop = counted | (cfg_q.pulses == '0);
        endcase
        stop = stop | stuck;
      end
      ST_BLANK: ;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cmd_prev_q <= 1'b0;
    else
      cmd_prev_q <= cfg_q.cmd_trig;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_q <= ST_IDLE;
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (start)
            state_q <= ST_ACTIVE;
          else if ((cfg_q.mode == MODE_SPI && cmd_rise) ||
                   (cfg_q.mode == MODE_ENPIN && io1_fall) ||
                   (cfg_q.mode == MODE_DIRECT &&
                    (io1_fall | io2_fall)))
            state_q <= ST_ARMED;
        ST_ARMED:
          if (cfg_q.mode == MODE_SPI && !cfg_q.cmd_trig)
            state_q <= ST_IDLE;
          else if (cfg_q.mode == MODE_ENPIN && io1_rise)
            state_q <= ST_IDLE;
          else if (start)
            state_q <= ST_ACTIVE;
        ST_ACTIVE:
          if (stop)
            state_q <= (cfg_q.mode == MODE_SINGLE) ? ST_BLANK : ST_IDLE;
        ST_BLANK:
          if (stuck)
            state_q <= ST_IDLE;
      endcase
    end
  end

  // Pulse counter, stuck timer and overlap timer
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      count_q <= '0;
      tmr_q   <= '0;
      ovl_q   <= '0;
    end
    else
    begin
      if (start)
        count_q <= '0;
      else if (state_q == ST_ACTIVE && io2_fall &&
               count_q != {PULSE_W{1'b1}})
        count_q <= count_q + PULSE_W'(1);
      // Active: restart on each toggle; blank: free count from burst end
      if (start || stop || (state_q == ST_ACTIVE && io_toggle))
        tmr_q <= '0;
      else if ((state_q == ST_ACTIVE || state_q == ST_BLANK) && !stuck)
        tmr_q <= tmr_q + TMR_W'(1);
      if (state_q == ST_ACTIVE && lvl_q[0] && lvl_q[1] && !overlap)
        ovl_q <= ovl_q + TMR_W'(1);
      else if (!(lvl_q[0] && lvl_q[1]) || state_q != ST_ACTIVE)
        ovl_q <= '0;
    end
  end

  // Fault flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pcnt_flt_q  <= 1'b0;
      stuck_flt_q <= 1'b0;
    end
    else
    begin
      if (start || standby_entry)
        pcnt_flt_q <= 1'b0;
      if (start || standby_entry || ftime_clr_wr)
        stuck_flt_q <= 1'b0;
      if (state_q == ST_ACTIVE && stop && short_count && !counted)
        pcnt_flt_q <= 1'b1;
      if (state_q == ST_ACTIVE && stuck)
        stuck_flt_q <= 1'b1;
    end
  end

  // Drive supply gating
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lstn_off_q <= 1'b0;
    else if (cfg_q.hi_z)
      lstn_off_q <= 1'b0;
    else if (state_q == ST_ACTIVE && stop && cfg_q.lstn_dis &&
             !cfg_q.recharge)
      lstn_off_q <= 1'b1;
    else if (recharge_set)
      lstn_off_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      charge_enable       <= 1'b0;
      drive_voltage_level <= VLEVEL_RESET;
    end
    else
    begin
      charge_enable       <= ~cfg_q.hi_z & ~lstn_off_q & ~lvl_q[2];
      drive_voltage_level <= cfg_q.vlevel;
    end
  end

  // Drive outputs: off outside a burst so neither FET conducts
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      drive_out_a <= 1'b0;
      drive_out_b <= 1'b0;
    end
    else if (state_q == ST_ACTIVE && !stop)
    begin
      if (cfg_q.mode == MODE_DIRECT)
      begin
        drive_out_a <= ~lvl_q[0];
        drive_out_b <= ~lvl_q[1];
      end
      else
      begin
        drive_out_a <= ~lvl_q[1];
        drive_out_b <= lvl_q[1];
      end
    end
    else
    begin
      drive_out_a <= 1'b0;
      drive_out_b <= 1'b0;
    end
  end

  // AXI4-Lite read
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb
  begin
    rd_word = '0;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      OFS_CTRL:
      begin
        rd_word[B_MODE_LO +: 2]   = cfg_q.mode;
        rd_word[B_CMD_TRIG]       = cfg_q.cmd_trig;
        rd_word[B_HI_Z]           = cfg_q.hi_z;
        rd_word[B_LSTN_DIS]       = cfg_q.lstn_dis;
        rd_word[B_RECHARGE]       = cfg_q.recharge;
        rd_word[B_VLEVEL_LO +: 4] = cfg_q.vlevel;
      end
      OFS_BURST:
      begin
        rd_word[B_PULSE_LO +: PULSE_W] = cfg_q.pulses;
        rd_word[B_FTIME_LO +: 3]       = cfg_q.ftime;
      end
      OFS_STATUS:
      begin
        rd_word[B_READY]     = ~cfg_q.hi_z & lvl_q[2];
        rd_word[B_PCNT_FLT]  = pcnt_flt_q;
        rd_word[B_STUCK_FLT] = stuck_flt_q;
        rd_word[B_ACTIVE]    = (state_q == ST_ACTIVE);
        rd_word[B_ARMED]     = (state_q == ST_ARMED);
        rd_word[B_BLANK]     = (state_q == ST_BLANK);
      end
      default:
        rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// file: tb/ubc_mcu_model.sv
// Microcontroller pin model: burst clock and enables on the IO pins
`timescale 1ns/1ps
module ubc_mcu_model (
  output logic first_io_pin,
  output logic second_io_pin
);
  // Half period of the pin clock in ns; raise it for a slow controller
  int half = 80;

  initial
  begin
    first_io_pin = 1'b1;
    second_io_pin = 1'b1;
  end

  // Clock idles high between frames; odd offset keeps it off clk phase
  task automatic clk2(input int n);
    #13;
    repeat (n)
    begin
      #half second_io_pin = 1'b0;
      #half second_io_pin = 1'b1;
    end
  endtask

  // Never both low or both high while alternating
  task automatic alt(input int n);
    #13;
    repeat (n)
    begin
      first_io_pin = 1'b0;
      second_io_pin = 1'b1;
      #half;
      first_io_pin = 1'b1;
      second_io_pin = 1'b0;
      #half;
    end
    second_io_pin = 1'b1;
  endtask

  task automatic set1(input logic v);
    #13 first_io_pin = v;
  endtask

  // Holding low on purpose emulates a lost burst clock
  task automatic set2(input logic v);
    #13 second_io_pin = v;
  endtask
endmodule

// file: tb/ubc_burst_ctrl_checker.sv
// Port-level assertions for the burst controller
`timescale 1ns/1ps
module ubc_burst_ctrl_checker
  import ubc_pkg::*;
#(
  parameter int unsigned FAULT_UNIT = FAULT_UNIT_CYC
)(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              first_io_pin,
  input wire logic              second_io_pin,
  input wire logic              supply_at_level,
  input wire logic              drive_out_a,
  input wire logic              drive_out_b,
  input wire logic              charge_enable
);
  int unsigned quiet_q;
  logic [1:0]  pins_q;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Cycles since either pin last moved, saturating
  always_ff @(posedge clk)
  begin
    pins_q <= {first_io_pin, second_io_pin};
    if (sys_rst || pins_q != {first_io_pin, second_io_pin})
      quiet_q <= 0;
    else if (quiet_q < 1000)
      quiet_q <= quiet_q + 1;
  end

  property p_rst_quiet;
    $fell(sys_rst) |-> !charge_enable && !drive_out_a && !drive_out_b;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active after reset");

  property p_level_off;
    supply_at_level [*8] |-> !charge_enable;
  endproperty
  a_level_off: assert property (p_level_off)
    else $error("charging while supply at level");

  // Window plus synchroniser slack
  property p_stuck_end;
    quiet_q > 8 * FAULT_UNIT + 12 |-> !drive_out_a && !drive_out_b;
  endproperty
  a_stuck_end: assert property (p_stuck_end)
    else $error("drive left on with idle pins");

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped early");

  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped early");

  property p_awpulse;
    s_axi_awready |=> !s_axi_awready;
  endproperty
  a_awpulse: assert property (p_awpulse)
    else $error("awready longer than one cycle");

  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer late");

  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_wr_ans;
    s_both_taken |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write answer late");

  property p_slverr;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr[3]
      |-> ##[1:4] s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("no error for unwritable address");

  c_burst: cover property ($rose(drive_out_a));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_charge: cover property ($fell(charge_enable));
endmodule

bind ubc_burst_ctrl ubc_burst_ctrl_checker #(
  .FAULT_UNIT(FAULT_UNIT)
) chk_inst (
  .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .first_io_pin, .second_io_pin,
  .supply_at_level, .drive_out_a, .drive_out_b, .charge_enable
);

// file: tb/ubc_burst_ctrl_test.sv
// Self-checking bench: register bus, pin model and burst modes
`timescale 1ns/1ps
module ubc_burst_ctrl_test;
  import ubc_pkg::*;
  localparam int unsigned FU = 4;
  localparam int unsigned LIMIT = 20000;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_wvalid;
  logic              s_axi_bready, s_axi_arvalid;
  logic              s_axi_rready, standby_mode;
  logic              supply_at_level = 1'b1, pa = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid, first_io_pin;
  logic              second_io_pin, drive_out_a, drive_out_b;
  logic              charge_enable;
  logic [3:0]        drive_voltage_level;
  logic [31:0]       mctrl = 32'h0000_0008, mburst = 32'h0000_0700;
  int                failures = 0, total_checks = 0, cycles = 0;
  int                seed = 56069, rises = 0, r0, n;

  ubc_burst_ctrl #(.FAULT_UNIT(FU), .OVL_CYC(3)) ubc_burst_ctrl_inst (
    .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .first_io_pin, .second_io_pin,
    .supply_at_level, .standby_mode, .drive_out_a, .drive_out_b,
    .charge_enable, .drive_voltage_level
  );
  ubc_mcu_model mcu (.first_io_pin, .second_io_pin);

  initial
  begin
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    pa <= drive_out_a;
    if (drive_out_a && !pa)
      rises <= rises + 1;
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      failures++;
      conclude();
    end
  end

  task automatic conclude;
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask

  // Each valid drops at the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ha;
    logic hw;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ha = 1'b0;
    hw = 1'b0;
    while (!(ha && hw))
    begin
      @(posedge clk);
      ha = ha | s_axi_awready;
      hw = hw | s_axi_wready;
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'b0;
    if (er === RESP_OKAY && a == OFS_CTRL) mctrl = d;
    if (er === RESP_OKAY && a == OFS_BURST) mburst = d;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    if (a != 4'hC) chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(a == 4'hC ? RESP_SLVERR : RESP_OKAY));
    s_axi_rready <= 1'b0;
  endtask

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} <= '0;
    {s_axi_rready, standby_mode, s_axi_awaddr, s_axi_araddr} <= '0;
    s_axi_wdata <= '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(OFS_CTRL, mctrl);
    rdc(OFS_BURST, mburst);
    rdc(OFS_STATUS, 32'h0);
    wr(4'hC, 32'($random(seed)), RESP_SLVERR);
    wr(OFS_STATUS, 32'hFFFF_FFFF, RESP_SLVERR);
    rdc(4'hC, 32'h0);
    wr(OFS_CTRL, 32'h0000_0038, RESP_OKAY);
    supply_at_level <= 1'b0;
    cyc(8);
    chk(32'(charge_enable), 32'h0);
    wr(OFS_CTRL, 32'h0000_0510, RESP_OKAY);
    cyc(8);
    chk(32'(charge_enable), 32'h1);
    chk(32'(drive_voltage_level), 32'(mctrl[11:8]));
    supply_at_level <= 1'b1;
    cyc(8);
    chk(32'(charge_enable), 32'h0);
    rdc(OFS_STATUS, 32'h1);
    supply_at_level <= 1'b0;
    // Second pass leaves recharge set across the burst
    for (int k = 0; k < 2; k++)
    begin
      n = 1 + ($random(seed) & 3);
      wr(OFS_BURST, 32'h0000_0700 | 32'(n), RESP_OKAY);
      wr(OFS_CTRL, 32'h0000_0514 | 32'(k << 5), RESP_OKAY);
      r0 = rises;
      mcu.clk2(n + 3);
      cyc(8);
      chk(32'(rises - r0), 32'(n));
      rdc(OFS_STATUS, 32'h0);
      chk(32'(charge_enable), 32'(k));
      wr(OFS_CTRL, 32'h0000_0530, RESP_OKAY);
      cyc(8);
      chk(32'(charge_enable), 32'h1);
    end
    wr(OFS_BURST, 32'h0000_0708, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0514, RESP_OKAY);
    fork
      mcu.clk2(6);
      begin
        cyc(26);
        wr(OFS_CTRL, 32'h0000_0510, RESP_OKAY);
      end
    join
    cyc(8);
    rdc(OFS_STATUS, 32'h2);
    chk(32'(charge_enable), 32'h0);
    standby_mode <= 1'b1;
    cyc(8);
    standby_mode <= 1'b0;
    rdc(OFS_STATUS, 32'h0);
    wr(OFS_BURST, 32'h0000_0700, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0511, RESP_OKAY);
    r0 = rises;
    mcu.half = 120;
    mcu.set1(1'b0);
    mcu.clk2(10);
    mcu.set1(1'b1);
    mcu.clk2(3);
    mcu.half = 80;
    cyc(8);
    chk(32'(rises - r0), 32'd10);
    wr(OFS_BURST, 32'h0000_0702, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0513, RESP_OKAY);
    r0 = rises;
    mcu.clk2(4);
    cyc(40);
    mcu.clk2(3);
    cyc(8);
    chk(32'(rises - r0), 32'd4);
    rdc(OFS_STATUS, 32'h0000_0020);
    cyc(40);
    wr(OFS_BURST, 32'h0000_0705, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0514, RESP_OKAY);
    mcu.set2(1'b0);
    cyc(50);
    chk(32'({drive_out_a, drive_out_b}), 32'h0);
    mcu.set2(1'b1);
    rdc(OFS_STATUS, 32'h6);
    wr(OFS_BURST, 32'h0000_0705, RESP_OKAY);
    rdc(OFS_STATUS, 32'h2);
    wr(OFS_BURST, 32'h0000_0701, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0512, RESP_OKAY);
    r0 = rises;
    mcu.set2(1'b0);
    cyc(4);
    mcu.set2(1'b1);
    cyc(8);
    chk(32'({drive_out_a, drive_out_b}), 32'h0);
    mcu.alt(3);
    cyc(8);
    chk(32'(rises - r0), 32'd3);
    r0 = rises;
    mcu.alt(2);
    cyc(8);
    chk(32'(rises - r0), 32'd1);
    rdc(OFS_CTRL, mctrl & 32'h0000_0F3F);
    rdc(OFS_BURST, mburst & 32'h0000_07FF);
    conclude();
  end
endmodule
